// File: ufsp_pkg.sv
// Shared constants for the second serial port
package ufsp_pkg;
    localparam int RX_DEPTH = 3;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [1:0] PS_12 = 2'h0;
    localparam logic [1:0] PS_4 = 2'h1;
    localparam logic [1:0] PS_48 = 2'h2;
    localparam logic [1:0] PS_1 = 2'h3;
    localparam logic [5:0] DIV_1 = 6'h01;
    localparam logic [5:0] DIV_4 = 6'h04;
    localparam logic [5:0] DIV_12 = 6'h0c;
    localparam logic [5:0] DIV_48 = 6'h30;
    localparam logic [1:0] PAR_ODD = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_MARK = 2'h2;
    localparam logic [1:0] PAR_SPACE = 2'h3;
    localparam logic [7:0] RXDATA_RST = 8'h00;
    localparam logic [3:0] SAMPLES_PER_BIT = 4'h2;
endpackage

// File: ufsp_skid.sv
// Two-entry valid/ready buffer for transmit bytes
`timescale 1ns/1ps
`default_nettype none
module ufsp_skid #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] mem_q [2];
    logic rd_q, wr_q;
    logic [1:0] cnt_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = cnt_q != 2'h2;
    assign out_valid_o = cnt_q != 2'h0;
    assign out_data_o = mem_q[rd_q];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data_i;
                wr_q <= ~wr_q;
            end
            if (pop) rd_q <= ~rd_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// File: ufsp_top.sv
// Second serial port: baud generator, transmitter, receiver, FIFO
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Transmit and receive machines run independently, full duplex.
// RULE2: Dedicated 16-bit baud timer behind a selectable prescaler.
// RULE3: Receive FIFO holds three bytes; a fourth overflows.
// RULE4: Six registers as plain ports: baud three, format and control, data.
// RULE5: Writes to the data location load the transmit holding path.
// RULE6: Reads of the data location return the oldest FIFO byte.
// RULE7: Transmit data has no read path.
// RULE8: Set transmit-done and receive flags; either interrupts when enabled.
// RULE9: Hardware never auto-clears the flags; software clears them.
// RULE10: Clearing receive-available is ignored while unread bytes remain.
// RULE11: Nothing runs unless the baud generator is enabled.
// RULE12: Timer counts up from reload, reloads on overflow; bit = 2 overflows.
// RULE13: Low start, 5-8 data LSB first, parity or extra, 1-2 high stops.
// RULE14: Even/odd/mark/space parity; no extra bit with parity; long stop 6-8.
// RULE15: Byte arriving to a full FIFO is dropped and overrun is flagged.
// RULE16: A read pops the FIFO; flag falls only when empty and cleared.
module ufsp_top #(
    parameter int DEPTH = ufsp_pkg::RX_DEPTH
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // Baud generator control
    input wire logic BAUD_EN_I,
    input wire logic [1:0] BAUD_PS_I,
    input wire logic [7:0] BAUD_RELOAD_HIGH_I,
    input wire logic [7:0] BAUD_RELOAD_LOW_I,
    // Frame format
    input wire logic [1:0] DATA_LEN_I,
    input wire logic PARITY_ENABLE_BIT_I,
    input wire logic [1:0] PARITY_TYPE_I,
    input wire logic EXTRA_BIT_ENABLE_I,
    input wire logic LONG_STOP_I,
    input wire logic TX_EXTRA_I,
    // Control and status
    input wire logic RX_ENABLE_I,
    input wire logic INT_ENABLE_I,
    input wire logic TX_FLAG_CLR_I,
    input wire logic RX_FLAG_CLR_I,
    input wire logic OVR_CLR_I,
    output logic TX_COMPLETE_FLAG_O,
    output logic RX_AVAILABLE_FLAG_O,
    output logic OVERRUN_O,
    output logic PARITY_ERR_O,
    output logic RX_EXTRA_O,
    output logic INT_O,
    // Shared data location
    input wire logic DATA_WR_I,
    input wire logic [7:0] DATA_WDATA_I,
    output logic DATA_WREADY_O,
    input wire logic DATA_RD_I,
    output logic [7:0] SERIAL_DATA_PORT_O,
    // Serial pins
    output logic TX_O,
    input wire logic RX_I
);
    logic rs1_q, rst_n;
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end
    logic rx1_q, rx_q;
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            rx1_q <= 1'b1;
            rx_q <= 1'b1;
        end else begin
            rx1_q <= RX_I;
            rx_q <= rx1_q;
        end
    end
    // Baud generator; each overflow is a half-bit tick
    logic [5:0] ps_q;
    logic [15:0] tmr_q;
    wire [5:0] ps_div = (BAUD_PS_I == ufsp_pkg::PS_1) ? ufsp_pkg::DIV_1 :
        (BAUD_PS_I == ufsp_pkg::PS_4) ? ufsp_pkg::DIV_4 :
        (BAUD_PS_I == ufsp_pkg::PS_48) ? ufsp_pkg::DIV_48 : ufsp_pkg::DIV_12;
    wire ps_tick = BAUD_EN_I && (ps_q >= ps_div - 6'h01); // RULE2 RULE11
    wire half_tick = ps_tick && (tmr_q == 16'hffff); // RULE12
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            ps_q <= 6'h00;
            tmr_q <= ufsp_pkg::RELOAD_RST;
        end else if (!BAUD_EN_I) begin
            ps_q <= 6'h00; // RULE11
            tmr_q <= {BAUD_RELOAD_HIGH_I, BAUD_RELOAD_LOW_I}; // RULE4
        end else begin
            ps_q <= ps_tick ? 6'h00 : ps_q + 6'h01;
            if (half_tick) tmr_q <= {BAUD_RELOAD_HIGH_I, BAUD_RELOAD_LOW_I};
            else if (ps_tick) tmr_q <= tmr_q + 16'h0001; // RULE12
        end
    end
    function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n,
                                     input logic [1:0] t);
        logic x;
        x = 1'b0;
        for (int i = 0; i < 8; i++) if (i < n) x = x ^ d[i];
        case (t)
            ufsp_pkg::PAR_ODD: par_bit = ~x;
            ufsp_pkg::PAR_EVEN: par_bit = x;
            ufsp_pkg::PAR_MARK: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    endfunction
    wire [3:0] nbits = 4'h5 + {2'b00, DATA_LEN_I}; // RULE13
    wire has_ext = PARITY_ENABLE_BIT_I || EXTRA_BIT_ENABLE_I; // RULE14
    // Long stop only counts with 6 to 8 data bits
    wire two_stop = LONG_STOP_I && (DATA_LEN_I != 2'h0); // RULE14
    // Start, data, extra, then one or two stops before the flag rises
    wire [3:0] frame_len = 4'h2 + nbits + {3'b000, has_ext}
        + {3'b000, two_stop}; // RULE13
    // Transmit holding buffer decouples software writes from the shifter
    logic hold_valid, hold_ready;
    logic [7:0] hold_data;
    ufsp_skid #(.W(8)) u_hold (
        .clk_i(CLOCK_I),
        .rst_n_i(rst_n),
        .in_valid_i(DATA_WR_I), // RULE5
        .in_ready_o(DATA_WREADY_O),
        .in_data_i(DATA_WDATA_I),
        .out_valid_o(hold_valid),
        .out_ready_i(hold_ready),
        .out_data_o(hold_data)
    );
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_RUN = 2'b10} ufsp_tx_e;
    ufsp_tx_e tx_st_q;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic tx_ph_q, tx_done;
    assign hold_ready = (tx_st_q == TX_IDLE) && BAUD_EN_I && half_tick;
    assign tx_done = (tx_st_q == TX_RUN) && half_tick && tx_ph_q
        && (tx_cnt_q == frame_len);
    wire tx_xb = PARITY_ENABLE_BIT_I ?
        par_bit(hold_data, nbits, PARITY_TYPE_I) : TX_EXTRA_I;
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_q <= TX_IDLE;
            tx_sh_q <= '1;
            tx_cnt_q <= 4'h0;
            tx_ph_q <= 1'b0;
            TX_O <= 1'b1;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    TX_O <= 1'b1;
                    if (hold_valid && hold_ready) begin
                        tx_sh_q <= 11'h7ff;
                        for (int i = 0; i < 8; i++)
                            if (i < nbits) tx_sh_q[i] <= hold_data[i]; // RULE13
                        if (has_ext) tx_sh_q[nbits] <= tx_xb; // RULE14
                        TX_O <= 1'b0;
                        tx_cnt_q <= 4'h1;
                        tx_ph_q <= 1'b0;
                        tx_st_q <= TX_RUN;
                    end
                end
                TX_RUN: if (half_tick) begin
                    tx_ph_q <= ~tx_ph_q;
                    if (tx_ph_q) begin
                        if (tx_done) tx_st_q <= TX_IDLE;
                        else begin
                            TX_O <= tx_sh_q[0];
                            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                            tx_cnt_q <= tx_cnt_q + 4'h1;
                        end
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end
    // Receiver samples once per bit, the first one half-bit after the low start is seen
    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RUN = 2'b10} ufsp_rx_e;
    ufsp_rx_e rx_st_q;
    logic [8:0] rx_sh_q;
    logic [3:0] rx_cnt_q;
    logic rx_ph_q;
    wire [3:0] rx_need = nbits + {3'b000, has_ext};
    wire rx_samp = (rx_st_q == RX_RUN) && half_tick && !rx_ph_q;
    wire rx_last = rx_samp && (rx_cnt_q == rx_need + 4'h1);
    wire [7:0] rx_byte = 8'(rx_sh_q >> (4'h9 - rx_need));
    wire [7:0] rx_data = (rx_byte & 8'(9'h0ff >> (4'h8 - nbits)));
    // Extra bit is the last one shifted in, so it sits at the top
    wire rx_xb = has_ext && rx_sh_q[8];
    wire rx_got = rx_last && rx_q; // RULE13
    // FIFO of received bytes
    logic [7:0] fifo_q [DEPTH];
    logic [1:0] fcnt_q;
    wire full = fcnt_q == 2'(DEPTH);
    wire pop = DATA_RD_I && (fcnt_q != 2'h0); // RULE16
    wire push = rx_got && (!full || pop); // RULE3
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_q <= RX_IDLE;
            rx_sh_q <= '0;
            rx_cnt_q <= 4'h0;
            rx_ph_q <= 1'b0;
            fcnt_q <= 2'h0;
            for (int i = 0; i < DEPTH; i++) fifo_q[i] <= ufsp_pkg::RXDATA_RST;
            PARITY_ERR_O <= 1'b0;
            RX_EXTRA_O <= 1'b0;
        end else begin
            case (rx_st_q)
                RX_IDLE: if (half_tick && !rx_q && RX_ENABLE_I) begin
                    rx_st_q <= RX_RUN; // RULE1
                    rx_cnt_q <= 4'h0;
                    // First sample lands mid start bit, half a bit later
                    rx_ph_q <= 1'b0;
                end
                RX_RUN: if (half_tick) begin
                    rx_ph_q <= ~rx_ph_q;
                    if (rx_samp) begin
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_cnt_q == 4'h0 && rx_q) rx_st_q <= RX_IDLE;
                        else if (rx_last) rx_st_q <= RX_IDLE;
                        else if (rx_cnt_q != 4'h0)
                            rx_sh_q <= {rx_q, rx_sh_q[8:1]};
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
            if (pop) begin
                for (int i = 0; i < DEPTH - 1; i++) fifo_q[i] <= fifo_q[i+1];
                // Vacated slot reads as zero once the FIFO drains
                fifo_q[DEPTH-1] <= ufsp_pkg::RXDATA_RST;
            end
            if (push) fifo_q[2'(fcnt_q - {1'b0, pop})] <= rx_data;
            fcnt_q <= fcnt_q + {1'b0, push} - {1'b0, pop};
            if (push) begin
                RX_EXTRA_O <= rx_xb;
                PARITY_ERR_O <= PARITY_ENABLE_BIT_I &&
                    (rx_xb != par_bit(rx_data, nbits, PARITY_TYPE_I)); // RULE14
            end
        end
    end
    assign SERIAL_DATA_PORT_O = fifo_q[0]; // RULE6 RULE7
    // Flags: hardware set beats software clear
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            TX_COMPLETE_FLAG_O <= 1'b0;
            RX_AVAILABLE_FLAG_O <= 1'b0;
            OVERRUN_O <= 1'b0;
        end else begin
            if (tx_done) TX_COMPLETE_FLAG_O <= 1'b1; // RULE8
            else if (TX_FLAG_CLR_I) TX_COMPLETE_FLAG_O <= 1'b0; // RULE9
            if (push) RX_AVAILABLE_FLAG_O <= 1'b1; // RULE8
            else if (RX_FLAG_CLR_I && (fcnt_q - {1'b0, pop}) == 2'h0)
                RX_AVAILABLE_FLAG_O <= 1'b0; // RULE10 RULE16
            if (rx_got && !push) OVERRUN_O <= 1'b1; // RULE15
            else if (OVR_CLR_I) OVERRUN_O <= 1'b0;
        end
    end
    assign INT_O = INT_ENABLE_I && (TX_COMPLETE_FLAG_O || RX_AVAILABLE_FLAG_O);
    // Assertions
    property p_ovr;
        @(posedge CLOCK_I) disable iff (!rst_n)
        (rx_got && full && !pop) |=> OVERRUN_O && $stable(fcnt_q);
    endproperty
    a_ovr: assert property (p_ovr) // RULE15
        else $error("overrun not flagged");
    property p_rxclr;
        @(posedge CLOCK_I) disable iff (!rst_n)
        (fcnt_q > 2'h1 && RX_AVAILABLE_FLAG_O) |=> RX_AVAILABLE_FLAG_O;
    endproperty
    a_rxclr: assert property (p_rxclr) // RULE10
        else $error("flag cleared early");
    property p_txset;
        @(posedge CLOCK_I) disable iff (!rst_n) tx_done |=> TX_COMPLETE_FLAG_O;
    endproperty
    a_txset: assert property (p_txset) // RULE8
        else $error("tx flag missing");
    property p_nohw_clr;
        @(posedge CLOCK_I) disable iff (!rst_n)
        (TX_COMPLETE_FLAG_O && !TX_FLAG_CLR_I) |=> TX_COMPLETE_FLAG_O;
    endproperty
    a_nohw_clr: assert property (p_nohw_clr) // RULE9
        else $error("tx flag lost");
    property p_full;
        @(posedge CLOCK_I) disable iff (!rst_n) fcnt_q <= 2'(DEPTH);
    endproperty
    a_full: assert property (p_full) // RULE3
        else $error("fifo count overflow");
    property p_pop;
        @(posedge CLOCK_I) disable iff (!rst_n)
        (pop && !push && fcnt_q > 2'h1)
            |=> SERIAL_DATA_PORT_O == $past(fifo_q[1]);
    endproperty
    a_pop: assert property (p_pop) // RULE16
        else $error("read did not advance");
    // A stopped generator freezes both machines and the line
    property p_off;
        @(posedge CLOCK_I) disable iff (!rst_n)
        !BAUD_EN_I |=> $stable(tx_st_q) && $stable(rx_st_q) && $stable(TX_O);
    endproperty
    a_off: assert property (p_off) // RULE11
        else $error("serial activity while off");
    sequence s_start;
        hold_valid && hold_ready;
    endsequence
    property p_start;
        @(posedge CLOCK_I) disable iff (!rst_n) s_start |=> !TX_O;
    endproperty
    a_start: assert property (p_start) // RULE13
        else $error("no start bit");
endmodule
`default_nettype wire

// File: ufsp_remote.sv
// Remote serial node model: sends frames and decodes received frames
`timescale 1ns/1ps
`default_nettype none
module ufsp_remote #(
    parameter int BIT = 8
) (
    // Clock
    input wire logic clk_i,
    // Serial lines
    input wire logic line_i,
    output logic line_o,
    // Bits after the start bit, data plus parity
    input wire logic [3:0] nbits_i
);
    logic [8:0] got[$];

    initial line_o = 1'b1;

    // Changes land just after an edge, like every other driver here
    task automatic hold;
        repeat (BIT) @(posedge clk_i);
        #1;
    endtask

    // Low start, LSB first, high stop; idle line stays high
    task automatic send(input logic [8:0] v, input int n);
        line_o = 1'b0;
        hold();
        for (int i = 0; i < n; i++) begin
            line_o = v[i];
            hold();
        end
        line_o = 1'b1;
        hold();
    endtask

    // Samples each bit in its middle; a wrong rate yields garbage
    initial forever begin
        logic [8:0] v;
        @(negedge line_i);
        repeat (BIT / 2) @(posedge clk_i);
        v = 9'h000;
        for (int i = 0; i < nbits_i; i++) begin
            repeat (BIT) @(posedge clk_i);
            v[i] = line_i;
        end
        repeat (BIT) @(posedge clk_i);
        got.push_back(v);
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the second serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // Reload fffc at prescale 1 gives 4-clock overflows, 8-clock bits
    localparam int BIT = 8;
    logic clk = 0, rst_n = 0, en = 0, pen = 0, ien = 1;
    logic xbe = 0, lstop = 0, rxe;
    logic tclr = 0, rclr = 0, oclr = 0, wr = 0, rd = 0;
    logic [1:0] ps = 2'h3, len = 2'h3, ptype = 2'h0;
    logic [15:0] rl = 16'hfffc;
    logic [7:0] wd = 8'h00, dport;
    logic [3:0] nb = 4'h8;
    logic txc, rxa, ovr, perr, irq, wrdy, tx, rxl;
    logic [2:0] fl;
    int num_errors = 0, checked = 0, cyc = 0, n;
    int dv[4] = '{1, 4, 12, 48};
    logic [1:0] pc[4] = '{2'h3, 2'h1, 2'h0, 2'h2};
    assign fl = {ovr, rxa, txc};

    ufsp_top i_ufsp_top (
        .CLOCK_I(clk), .RST_N_I(rst_n), .BAUD_EN_I(en), .BAUD_PS_I(ps),
        .BAUD_RELOAD_HIGH_I(rl[15:8]), .BAUD_RELOAD_LOW_I(rl[7:0]),
        .DATA_LEN_I(len), .PARITY_ENABLE_BIT_I(pen), .PARITY_TYPE_I(ptype),
        .EXTRA_BIT_ENABLE_I(xbe), .LONG_STOP_I(lstop), .TX_EXTRA_I(xbe),
        .RX_ENABLE_I(1'b1), .INT_ENABLE_I(ien), .TX_FLAG_CLR_I(tclr),
        .RX_FLAG_CLR_I(rclr), .OVR_CLR_I(oclr), .TX_COMPLETE_FLAG_O(txc),
        .RX_AVAILABLE_FLAG_O(rxa), .OVERRUN_O(ovr), .PARITY_ERR_O(perr),
        .RX_EXTRA_O(rxe), .INT_O(irq), .DATA_WR_I(wr), .DATA_WDATA_I(wd),
        .DATA_WREADY_O(wrdy), .DATA_RD_I(rd), .SERIAL_DATA_PORT_O(dport),
        .TX_O(tx), .RX_I(rxl)
    );
    ufsp_remote #(.BIT(BIT)) i_ufsp_remote (
        .clk_i(clk), .line_i(tx), .line_o(rxl), .nbits_i(nb)
    );

    always #10 clk = ~clk;

    task automatic conclude;
        if (num_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs under 10000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            $display("BAD %0t run did not finish", $time);
            conclude();
        end
    end

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tk(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // Ready is combinational, so wait for it before raising the write
    task automatic wrb(input logic [7:0] v);
        while (wrdy !== 1'b1) tk(1);
        wd = v;
        wr = 1;
        tk(1);
        wr = 0;
    endtask

    task automatic rdb;
        rd = 1;
        tk(1);
        rd = 0;
    endtask

    task automatic clr(input logic [2:0] m);
        {oclr, rclr, tclr} = m;
        tk(1);
        {oclr, rclr, tclr} = 3'h0;
        tk(1);
    endtask

    task automatic waitf(input int k);
        n = 0;
        while (fl[k] !== 1'b1 && n < 4000) begin
            n++;
            tk(1);
        end
        chk(fl[k], 1'b1);
    endtask

    task automatic heard(input logic [8:0] e);
        chk(i_ufsp_remote.got.size() > 0 ?
            i_ufsp_remote.got.pop_front() : 9'hxxx, e);
    endtask

    initial begin
        tk(2);
        rst_n = 1;
        tk(3);
        chk({tx, txc, rxa, ovr, wrdy}, 5'h11);
        chk(dport, 8'h00);
        // Generator loads its reload value while off, so enable it last
        en = 1;
        // Send and receive at once
        wrb(8'ha5);
        fork
            i_ufsp_remote.send(9'h03c, 8);
        join_none
        waitf(0);
        chk(irq, 1'b1);
        waitf(1);
        heard(9'h0a5);
        chk(dport, 8'h3c);
        tk(40);
        chk({txc, rxa}, 2'h3);
        ien = 0;
        tk(1);
        chk(irq, 1'b0);
        ien = 1;
        clr(3'h1);
        rdb();
        clr(3'h2);
        chk({txc, rxa, irq}, 3'h0);
        // Fourth byte into a full FIFO is dropped
        for (int i = 0; i < 4; i++) i_ufsp_remote.send(9'h010 + i, 8);
        tk(4);
        chk(ovr, 1'b1);
        for (int i = 0; i < 3; i++) begin
            chk(dport, 8'h10 + i);
            clr(3'h2);
            chk(rxa, 1'b1);
            rdb();
        end
        chk(dport, 8'h00);
        clr(3'h2);
        chk(rxa, 1'b0);
        clr(3'h4);
        chk(ovr, 1'b0);
        wrb(8'h77);
        tk(1);
        chk(dport, 8'h00);
        waitf(0);
        heard(9'h077);
        clr(3'h1);
        // Stopped generator holds the line idle
        en = 0;
        wrb(8'h33);
        tk(200);
        chk(tx, 1'b1);
        en = 1;
        waitf(0);
        heard(9'h033);
        clr(3'h1);
        // Three ones: odd and space give 0, even and mark give 1
        pen = 1;
        nb = 4'h9;
        for (int p = 0; p < 4; p++) begin
            ptype = p[1:0];
            wrb(8'h07);
            waitf(0);
            clr(3'h1);
            heard({p == 1 || p == 2, 8'h07});
            i_ufsp_remote.send({p == 1 || p == 2, 8'h07}, 9);
            waitf(1);
            chk({perr, dport}, 9'h007);
            rdb();
            clr(3'h2);
        end
        i_ufsp_remote.send(9'h107, 9);
        waitf(1);
        chk(perr, 1'b1);
        rdb();
        clr(3'h2);
        // Five data bits only
        pen = 0;
        len = 2'h0;
        nb = 4'h5;
        wrb(8'hff);
        waitf(0);
        heard(9'h01f);
        clr(3'h1);
        // Extra bit and two stops: the frame lasts twelve bit times
        len = 2'h3;
        xbe = 1;
        lstop = 1;
        nb = 4'h9;
        wrb(8'h5a);
        while (tx !== 1'b0) tk(1);
        n = 0;
        while (txc !== 1'b1) begin
            n++;
            tk(1);
        end
        chk(n[8:0], 12 * BIT);
        heard(9'h15a);
        clr(3'h1);
        i_ufsp_remote.send(9'h1c3, 9);
        waitf(1);
        chk({rxe, dport}, 9'h1c3);
        rdb();
        clr(3'h2);
        xbe = 0;
        lstop = 0;
        // Start bit lasts two overflows of 2 times the prescale
        len = 2'h3;
        rl = 16'hfffe;
        for (int i = 0; i < 4; i++) begin
            ps = pc[i];
            wrb(8'hff);
            while (tx !== 1'b0) tk(1);
            n = 0;
            while (tx === 1'b0) begin
                n++;
                tk(1);
            end
            chk(n[8:0], 4 * dv[i]);
            waitf(0);
            clr(3'h1);
        end
        tk(100);
        conclude();
    end
endmodule
`default_nettype wire
